// *** hw/port_f_g_h_alternate_override.sv ***
// Behaviour
// RQ1 - Test port enable forces upper Port F pull-ups, direction and input disable.
// RQ2 - Test logic runs from the tester-supplied clock on Port F bit 4.
// RQ3 - Test port on: F7/F5/F4 inputs, F6 output; off: converter and I/O.
// RQ4 - Test data out pin driven only in shift states, else pulled high.
// RQ5 - Port F bits 3 to 0 have no digital override, converter only.
// RQ6 - Port G bit 5 is input only with pull-up always on.
// RQ7 - Port G bit 5 is reset input unless the disable fuse is zero.
// RQ8 - Port G bit 4 feeds counter 0 source or drives a segment line.
// RQ9 - Port G bit 3 feeds counter 1 source or drives a segment line.
// RQ10 - Port G bits 2 to 0 drive segment lines.
// RQ11 - G4 under display: pull-up off, output, input off with mask.
// RQ12 - G3..G0 under display: pull-up off, input; input off with mask, G2 unqualified.
// RQ13 - Port H pins are pin-change sources 23 to 16 or segment lines.
// RQ14 - Port H logic exists only on the larger pinout.
// RQ15 - Overrides act combinationally and win over the port register value.
`include "port_override_map.svh"
`timescale 1ns/10ps
`default_nettype none

module port_f_g_h_alternate_override
    import port_override_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [7:0] rdata,
    // Static configuration
    input wire logic large_pinout,
    input wire logic reset_pin_disable_fuse,
    // General-purpose port requests
    input wire gpio_t gpio_f,
    input wire gpio_t gpio_g,
    input wire gpio_t gpio_h,
    // Test controller side
    input wire logic tap_shift_ir,
    input wire logic tap_shift_dr,
    input wire logic tap_data_out,
    output var tap_pins_t tap_pins,
    // Pad levels seen at the pins
    input wire logic [7:0] pad_in_f,
    input wire logic [7:0] pad_in_g,
    input wire logic [7:0] pad_in_h,
    // Pad control
    output var pad_t pad_f,
    output var pad_t pad_g,
    output var pad_t pad_h,
    // Analog connections
    output logic [7:0] adc_channel_connect,
    output logic [7:0] segment_drive_g,
    output logic [7:0] segment_drive_h,
    // Peripheral inputs
    output logic counter0_external_source,
    output logic counter1_external_source,
    output logic external_reset_request,
    output logic [7:0] pin_change_source_h,
    output logic [7:0] port_in_f,
    output logic [7:0] port_in_g,
    output logic [7:0] port_in_h
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    state_t state_reg;
    state_t state_next;
    override_t ovr_f;
    override_t ovr_g;
    override_t ovr_h;
    logic test_on;
    logic lcd_on;
    logic lcd_masked;
    logic tap_shifting;

    assign test_on = state_reg.ctrl.test_port_enable;
    assign lcd_on = state_reg.ctrl.display_driver_enable;
    assign lcd_masked = lcd_on & state_reg.ctrl.segment_port_mask;
    assign tap_shifting = tap_shift_ir | tap_shift_dr;

    // ----------------------------------------
    // Override merge
    // ----------------------------------------
    function automatic logic [7:0] pick(
        input logic [7:0] en,
        input logic [7:0] val,
        input logic [7:0] dflt
    );
        pick = (en & val) | (~en & dflt);
    endfunction

    function automatic pad_t merge(
        input override_t o,
        input gpio_t g
    );
        pad_t p;
        p.pull_en = pick(o.pu_oe, o.pu_ov, g.pull & ~g.dir);
        p.oe = pick(o.dd_oe, o.dd_ov, g.dir);
        p.out = pick(o.pv_oe, o.pv_ov, g.out);
        p.in_dis = pick(o.di_oe, o.di_ov, `OVR_BYTE_RESET);
        merge = p;
    endfunction

    // ----------------------------------------
    // Port F overrides
    // ----------------------------------------
    always_comb
    begin
        ovr_f = '0;
        // Lower nibble never gets an override term
        if (test_on) // RQ5
        begin
            ovr_f.pu_oe = `OVR_F_JTAG_MASK; // RQ1
            // Pull-up keeps an idle data-out pin high
            ovr_f.pu_ov = `OVR_F_JTAG_MASK; // RQ1
            ovr_f.dd_oe = `OVR_F_JTAG_MASK; // RQ1
            ovr_f.di_oe = `OVR_F_JTAG_MASK; // RQ1
            ovr_f.di_ov = `OVR_F_JTAG_MASK; // RQ1
            ovr_f.dd_ov[`OVR_F_TDO] = tap_shifting; // RQ4
            ovr_f.pv_oe[`OVR_F_TDO] = 1'b1; // RQ3
            ovr_f.pv_ov[`OVR_F_TDO] = tap_data_out; // RQ3
        end
    end

    // ----------------------------------------
    // Port G overrides
    // ----------------------------------------
    always_comb
    begin
        ovr_g = '0;
        // Reset pin: input only, pull-up held on in every case
        ovr_g.pu_oe[`OVR_G_RESET] = 1'b1; // RQ6
        ovr_g.pu_ov[`OVR_G_RESET] = 1'b1; // RQ6
        ovr_g.dd_oe[`OVR_G_RESET] = 1'b1; // RQ6
        ovr_g.pv_oe[`OVR_G_RESET] = 1'b1; // RQ6
        if (lcd_on)
        begin
            ovr_g.pu_oe = ovr_g.pu_oe | `OVR_G_SEG_PINS; // RQ11 RQ12
            ovr_g.dd_oe = ovr_g.dd_oe | `OVR_G_SEG_PINS; // RQ11 RQ12
            ovr_g.dd_ov[`OVR_G_CNT0] = 1'b1; // RQ11
            if (lcd_masked) // RQ11 RQ12
            begin
                ovr_g.di_oe = ovr_g.di_oe | `OVR_G_SEG_PINS;
            end
            // Bit 2 ignores the mask
            ovr_g.di_oe[`OVR_G_SEG_FULL] = 1'b1; // RQ12
            // Value one cuts the digital input path
            ovr_g.di_ov = ovr_g.di_oe; // RQ11 RQ12
        end
    end

    // ----------------------------------------
    // Port H overrides
    // ----------------------------------------
    always_comb
    begin
        ovr_h = '0;
        if (lcd_on)
        begin
            ovr_h.pu_oe = 8'hFF; // RQ13
            ovr_h.dd_oe = 8'hFF; // RQ13
            // Pin-change enable term left out; mask alone gates the input
            if (lcd_masked) // RQ13
            begin
                ovr_h.di_oe = 8'hFF;
            end
            ovr_h.di_ov = ovr_h.di_oe; // RQ13
        end
    end

    // ----------------------------------------
    // Pad control
    // ----------------------------------------
    always_comb
    begin
        pad_f = merge(ovr_f, gpio_f); // RQ15
        pad_g = merge(ovr_g, gpio_g); // RQ15
        pad_h = merge(ovr_h, gpio_h); // RQ15
        // Unbonded upper Port G bits stay quiet
        pad_g.pull_en = pad_g.pull_en & `OVR_G_PINS;
        pad_g.oe = pad_g.oe & `OVR_G_PINS;
        pad_g.out = pad_g.out & `OVR_G_PINS;
        pad_g.in_dis = pad_g.in_dis & `OVR_G_PINS;
        // Small part has no Port H pads
        if (!large_pinout) // RQ14
        begin
            pad_h = '0;
        end
    end

    // ----------------------------------------
    // Analog connections
    // ----------------------------------------
    always_comb
    begin
        adc_channel_connect = `OVR_F_ADC_LOW; // RQ5
        if (!test_on) // RQ3
        begin
            adc_channel_connect = 8'hFF;
        end
        // Front plane number per pin depends on pinout, wired in the pad ring
        segment_drive_g = lcd_on ? `OVR_G_SEG_PINS : 8'h00; // RQ8 RQ9 RQ10
        segment_drive_h = (lcd_on && large_pinout) ? 8'hFF : 8'h00; // RQ13 RQ14
    end

    // ----------------------------------------
    // Peripheral inputs
    // ----------------------------------------
    always_comb
    begin
        // Synchronised copy; the tester must keep its clock well below clk
        tap_pins.tck = test_on & state_reg.f_sync[`OVR_F_TCK]; // RQ2
        tap_pins.tms = test_on & state_reg.f_sync[`OVR_F_TMS]; // RQ3
        tap_pins.tdi = test_on & state_reg.f_sync[`OVR_F_TDI]; // RQ3
        counter0_external_source = state_reg.g_sync[`OVR_G_CNT0]; // RQ8
        counter1_external_source = state_reg.g_sync[`OVR_G_CNT1]; // RQ9
        // Fuse at one keeps the pin as reset; zero frees it as plain input
        external_reset_request = reset_pin_disable_fuse & ~state_reg.g_sync[`OVR_G_RESET]; // RQ7
        pin_change_source_h = large_pinout ? state_reg.h_sync : 8'h00; // RQ13 RQ14
        // Cut input paths read as zero
        port_in_f = state_reg.f_sync & ~pad_f.in_dis;
        port_in_g = state_reg.g_sync & ~pad_g.in_dis & `OVR_G_PINS;
        port_in_h = large_pinout ? (state_reg.h_sync & ~pad_h.in_dis) : 8'h00; // RQ14
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        state_next = state_reg;
        state_next.f_meta = pad_in_f;
        state_next.f_sync = state_reg.f_meta;
        state_next.g_meta = pad_in_g;
        state_next.g_sync = state_reg.g_meta;
        state_next.h_meta = pad_in_h;
        state_next.h_sync = state_reg.h_meta;
        if (write_strobe && addr == `OVR_CTRL_ADDR)
        begin
            state_next.ctrl.test_port_enable = wdata[`OVR_CTRL_TEST_BIT];
            state_next.ctrl.display_driver_enable = wdata[`OVR_CTRL_LCD_BIT];
            state_next.ctrl.segment_port_mask = wdata[`OVR_CTRL_MASK_BIT];
        end
        // Read data stands for one cycle only
        state_next.rdata = `OVR_BYTE_RESET;
        if (read_strobe)
        begin
            case (addr)
                `OVR_CTRL_ADDR:
                begin
                    state_next.rdata = {5'h0, state_reg.ctrl};
                end
                `OVR_STAT_F_ADDR:
                begin
                    state_next.rdata = state_reg.f_sync;
                end
                `OVR_STAT_G_ADDR:
                begin
                    state_next.rdata = state_reg.g_sync & `OVR_G_PINS;
                end
                `OVR_STAT_H_ADDR:
                begin
                    state_next.rdata = large_pinout ? state_reg.h_sync : 8'h00;
                end
                default:
                begin
                    state_next.rdata = `OVR_UNMAPPED_READ;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg.f_meta <= `OVR_BYTE_RESET;
            state_reg.f_sync <= `OVR_BYTE_RESET;
            state_reg.g_meta <= `OVR_BYTE_RESET;
            state_reg.g_sync <= `OVR_BYTE_RESET;
            state_reg.h_meta <= `OVR_BYTE_RESET;
            state_reg.h_sync <= `OVR_BYTE_RESET;
            state_reg.ctrl <= ctrl_t'(`OVR_CTRL_RESET);
            state_reg.rdata <= `OVR_BYTE_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign rdata = state_reg.rdata;

endmodule

`default_nettype wire

// *** hw/port_override_map.svh ***
`ifndef PORT_OVERRIDE_MAP_SVH
`define PORT_OVERRIDE_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OVR_CTRL_ADDR 4'h0
`define OVR_STAT_F_ADDR 4'h1
`define OVR_STAT_G_ADDR 4'h2
`define OVR_STAT_H_ADDR 4'h3

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define OVR_CTRL_TEST_BIT 0
`define OVR_CTRL_LCD_BIT 1
`define OVR_CTRL_MASK_BIT 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define OVR_CTRL_RESET 3'h0
`define OVR_BYTE_RESET 8'h00
`define OVR_UNMAPPED_READ 8'h00

// ----------------------------------------
// Pin positions
// ----------------------------------------
`define OVR_F_TDI 7
`define OVR_F_TDO 6
`define OVR_F_TMS 5
`define OVR_F_TCK 4
`define OVR_G_RESET 5
`define OVR_G_CNT0 4
`define OVR_G_CNT1 3
`define OVR_G_SEG_FULL 2
`define OVR_F_JTAG_MASK 8'hF0
`define OVR_F_ADC_LOW 8'h0F
`define OVR_G_PINS 8'h3F
`define OVR_G_SEG_PINS 8'h1F

`endif

// *** hw/port_override_pkg.sv ***
package port_override_pkg;

    typedef struct packed {
        logic [7:0] pull;
        logic [7:0] dir;
        logic [7:0] out;
    } gpio_t;

    typedef struct packed {
        logic [7:0] pull_en;
        logic [7:0] oe;
        logic [7:0] out;
        logic [7:0] in_dis;
    } pad_t;

    typedef struct packed {
        logic [7:0] pu_oe;
        logic [7:0] pu_ov;
        logic [7:0] dd_oe;
        logic [7:0] dd_ov;
        logic [7:0] pv_oe;
        logic [7:0] pv_ov;
        logic [7:0] di_oe;
        logic [7:0] di_ov;
    } override_t;

    typedef struct packed {
        logic segment_port_mask;
        logic display_driver_enable;
        logic test_port_enable;
    } ctrl_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tap_pins_t;

    typedef struct packed {
        logic [7:0] f_meta;
        logic [7:0] f_sync;
        logic [7:0] g_meta;
        logic [7:0] g_sync;
        logic [7:0] h_meta;
        logic [7:0] h_sync;
        ctrl_t ctrl;
        logic [7:0] rdata;
    } state_t;

endpackage

// *** dv/pad_ring_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module pad_ring_model
    import port_override_pkg::*;
(
    // Clock
    input wire logic clk,
    // Pad control
    input wire pad_t pad_f,
    input wire pad_t pad_g,
    input wire pad_t pad_h,
    // Outside drivers as {h, g, f}
    input wire logic [23:0] drv_en,
    input wire logic [23:0] drv_val,
    // Pin levels
    output logic [7:0] pad_in_f,
    output logic [7:0] pad_in_g,
    output logic [7:0] pad_in_h
);
    // ----------
    // Pin levels
    // ----------
    // Undriven pins without pull-up wander, so a stale level never passes
    logic [23:0] float_reg = 24'h5A_5A5A;
    logic [23:0] oe;
    logic [23:0] pu;
    always @(posedge clk) float_reg <= ~float_reg;
    assign oe = {pad_h.oe, pad_g.oe, pad_f.oe};
    assign pu = {pad_h.pull_en, pad_g.pull_en, pad_f.pull_en};
    assign {pad_in_h, pad_in_g, pad_in_f} = (oe & {pad_h.out, pad_g.out, pad_f.out})
        | (~oe & drv_en & drv_val) | (~oe & ~drv_en & (pu | float_reg));
endmodule

`default_nettype wire

// *** dv/port_override_checker.sv ***
`timescale 1ns/10ps
`default_nettype none

module port_override_checker
    import port_override_pkg::*;
(
    // Clock, reset, config
    input wire logic clk,
    input wire logic nrst,
    input wire logic large_pinout,
    input wire logic reset_pin_disable_fuse,
    // Requests
    input wire gpio_t gpio_f,
    input wire gpio_t gpio_g,
    input wire logic tap_shift_ir,
    input wire logic tap_shift_dr,
    input wire logic tap_data_out,
    input wire logic [7:0] pad_in_g,
    input wire logic [7:0] pad_in_h,
    // Outputs
    input wire pad_t pad_f,
    input wire pad_t pad_g,
    input wire logic [7:0] adc_channel_connect,
    input wire logic [7:0] segment_drive_g,
    input wire logic [7:0] segment_drive_h,
    input wire logic counter0_external_source,
    input wire logic counter1_external_source,
    input wire logic external_reset_request,
    input wire logic [7:0] pin_change_source_h
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic tst = !adc_channel_connect[4];
    // ----------
    // Pin settling, two sync stages
    // ----------
    // Wandering G7/G6 must not mask the G5..G3 checks; reset empties the sync stages
    sequence s_g_settled; (nrst && $stable(pad_in_g[5:3]))[*3]; endsequence
    sequence s_h_settled; (nrst && $stable(pad_in_h))[*3]; endsequence
    property p_f_take; tst |-> pad_f.pull_en[7:4] == 4'hF && pad_f.in_dis[7:4] == 4'hF; endproperty
    property p_f_in; tst |-> !pad_f.oe[7] && pad_f.oe[5:4] == 2'h0; endproperty
    property p_tdo; tst |-> pad_f.oe[6] == (tap_shift_ir | tap_shift_dr) && pad_f.out[6] == tap_data_out; endproperty
    property p_f_low; pad_f.in_dis[3:0] == 4'h0 && pad_f.oe[3:0] == gpio_f.dir[3:0]
        && adc_channel_connect[3:0] == 4'hF; endproperty
    property p_g5; pad_g.pull_en[5] && !pad_g.oe[5]; endproperty
    property p_rst; s_g_settled |-> external_reset_request == (reset_pin_disable_fuse && !pad_in_g[5]); endproperty
    property p_cnt; s_g_settled |-> counter0_external_source == pad_in_g[4]
        && counter1_external_source == pad_in_g[3]; endproperty
    property p_seg; segment_drive_g[4:0] == 5'h00 || segment_drive_g[4:0] == 5'h1F; endproperty
    property p_g4; segment_drive_g[4] |-> !pad_g.pull_en[4] && pad_g.oe[4]; endproperty
    property p_glow; segment_drive_g[0] |-> pad_g.pull_en[3:0] == 4'h0 && pad_g.oe[3:0] == 4'h0 && pad_g.in_dis[2];
    endproperty
    property p_h; s_h_settled |-> pin_change_source_h == (large_pinout ? pad_in_h : 8'h00); endproperty
    property p_hsmall; !large_pinout |-> segment_drive_h == 8'h00; endproperty
    property p_plain; !segment_drive_g[0] |-> pad_g.oe[4:0] == gpio_g.dir[4:0]; endproperty
    a_f_take: assert property (p_f_take) else $error("f upper not taken");
    a_f_in: assert property (p_f_in) else $error("f test inputs driven");
    a_tdo: assert property (p_tdo) else $error("tdo drive wrong");
    a_f_low: assert property (p_f_low) else $error("f lower overridden");
    a_g5: assert property (p_g5) else $error("g5 pad wrong");
    a_rst: assert property (p_rst) else $error("reset pin wrong");
    a_cnt: assert property (p_cnt) else $error("counter source wrong");
    a_seg: assert property (p_seg) else $error("g segments split");
    a_g4: assert property (p_g4) else $error("g4 display pad wrong");
    a_glow: assert property (p_glow) else $error("g3..g0 display pad wrong");
    a_h: assert property (p_h) else $error("h source wrong");
    a_hsmall: assert property (p_hsmall) else $error("h alive on small part");
    a_plain: assert property (p_plain) else $error("g direction overridden");
endmodule

bind port_f_g_h_alternate_override port_override_checker chk_u (
    .clk(clk), .nrst(nrst), .large_pinout(large_pinout), .reset_pin_disable_fuse(reset_pin_disable_fuse),
    .gpio_f(gpio_f), .gpio_g(gpio_g), .tap_shift_ir(tap_shift_ir), .tap_shift_dr(tap_shift_dr),
    .tap_data_out(tap_data_out), .pad_in_g(pad_in_g), .pad_in_h(pad_in_h), .pad_f(pad_f), .pad_g(pad_g),
    .adc_channel_connect(adc_channel_connect), .segment_drive_g(segment_drive_g),
    .segment_drive_h(segment_drive_h), .counter0_external_source(counter0_external_source),
    .counter1_external_source(counter1_external_source), .external_reset_request(external_reset_request),
    .pin_change_source_h(pin_change_source_h)
);

`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none

module testbench;
    import port_override_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic write_strobe = 1'b0, read_strobe = 1'b0, large_pinout = 1'b1, reset_pin_disable_fuse = 1'b1;
    gpio_t gpio_f = {8'h00, 8'hFF, 8'h5A};
    gpio_t gpio_g = {8'hFF, 8'h20, 8'h3F};
    gpio_t gpio_h = {8'hFF, 8'h00, 8'h00};
    logic tap_shift_ir = 1'b0, tap_shift_dr = 1'b0, tap_data_out = 1'b0;
    logic [23:0] drv_en = 24'h00_0000, drv_val = 24'h00_0000;
    logic [7:0] rdata, pad_in_f, pad_in_g, pad_in_h, adc, sg, sh, pch, pin_f, pin_g, pin_h;
    logic c0, c1, xrst;
    tap_pins_t tap_pins;
    pad_t pad_f, pad_g, pad_h;
    int errors = 0, samples_checked = 0;

    initial forever #20 clk = ~clk;

    port_f_g_h_alternate_override dut_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
        .write_strobe(write_strobe), .read_strobe(read_strobe), .rdata(rdata), .large_pinout(large_pinout),
        .reset_pin_disable_fuse(reset_pin_disable_fuse), .gpio_f(gpio_f), .gpio_g(gpio_g), .gpio_h(gpio_h),
        .tap_shift_ir(tap_shift_ir), .tap_shift_dr(tap_shift_dr), .tap_data_out(tap_data_out),
        .tap_pins(tap_pins), .pad_in_f(pad_in_f), .pad_in_g(pad_in_g), .pad_in_h(pad_in_h), .pad_f(pad_f),
        .pad_g(pad_g), .pad_h(pad_h), .adc_channel_connect(adc), .segment_drive_g(sg), .segment_drive_h(sh),
        .counter0_external_source(c0), .counter1_external_source(c1), .external_reset_request(xrst),
        .pin_change_source_h(pch), .port_in_f(pin_f), .port_in_g(pin_g), .port_in_h(pin_h));

    pad_ring_model pads_u (.clk(clk), .pad_f(pad_f), .pad_g(pad_g), .pad_h(pad_h), .drv_en(drv_en),
        .drv_val(drv_val), .pad_in_f(pad_in_f), .pad_in_g(pad_in_g), .pad_in_h(pad_in_h));

    // ----------
    // Helpers
    // ----------
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        write_strobe <= 1'b1;
        @(posedge clk);
        write_strobe <= 1'b0;
    endtask

    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        read_strobe <= 1'b1;
        @(posedge clk);
        read_strobe <= 1'b0;
        @(negedge clk);
        chk("rdata", rdata, e);
    endtask

    // Two sync stages plus margin
    task settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task do_reset;
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
    endtask

    task final_report;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ----------
    // Tests
    // ----------
    initial
    begin
        do_reset;
        rd(4'h0, 8'h00);
        wr(4'h1, 8'h07);
        rd(4'h0, 8'h00);
        rd(4'h5, 8'h00);
        settle(1);
        chk("pad_f", pad_f, {8'h00, 8'hFF, 8'h5A, 8'h00});
        chk("pad_g", {pad_g.pull_en[5:0], pad_g.oe[5:0], pad_g.in_dis[5:0]}, 18'h3_F000);
        chk("pad_h", pad_h, 32'hFF00_0000);
        wr(4'h0, 8'h01);
        rd(4'h0, 8'h01);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk);
            {tap_shift_ir, tap_shift_dr, tap_data_out} <= {i == 1, i == 0, i == 1};
            settle(1);
            chk("pad_f", pad_f, {8'hF0, i < 2 ? 8'h4F : 8'h0F, i == 1 ? 8'h5A : 8'h1A, 8'hF0});
            chk("adc", adc, 8'h0F);
        end
        // Tester drives its own clock on the F4 pin
        @(posedge clk);
        drv_en <= 24'h00_00B0;
        drv_val <= 24'h00_0090;
        settle(3);
        chk("tap", tap_pins, 3'b101);
        chk("in_f", pin_f, 8'h0A);
        @(posedge clk);
        drv_val <= 24'h00_0020;
        settle(3);
        chk("tap", tap_pins, 3'b010);
        wr(4'h0, 8'h00);
        settle(3);
        chk("tap", tap_pins, 3'b000);
        chk("pad_f", pad_f, {8'h00, 8'hFF, 8'h5A, 8'h00});
        chk("adc", adc, 8'hFF);
        wr(4'h0, 8'h06);
        settle(1);
        chk("pad_g", {pad_g.pull_en[5:0], pad_g.oe[5:0], pad_g.in_dis[5:0]}, 18'h2_041F);
        chk("seg_g", sg, 8'h1F);
        wr(4'h0, 8'h02);
        settle(1);
        chk("pad_g", {pad_g.pull_en[5:0], pad_g.oe[5:0], pad_g.in_dis[5:0]}, 18'h2_0404);
        wr(4'h0, 8'h00);
        drv_en <= 24'h00_3800;
        drv_val <= 24'h00_1000;
        settle(3);
        chk("g_in", {c0, c1, xrst}, 3'b101);
        chk("in_g", pin_g, 8'h17);
        rd(4'h2, 8'h17);
        @(posedge clk);
        drv_val <= 24'h00_2800;
        settle(3);
        chk("g_in", {c0, c1, xrst}, 3'b010);
        @(posedge clk);
        drv_en <= 24'hFF_3800;
        drv_val <= 24'hA5_1000;
        wr(4'h0, 8'h02);
        settle(3);
        chk("pch", pch, 8'hA5);
        chk("seg_h", sh, 8'hFF);
        chk("in_h", pin_h, 8'hA5);
        rd(4'h3, 8'hA5);
        @(posedge clk);
        large_pinout <= 1'b0;
        reset_pin_disable_fuse <= 1'b0;
        do_reset;
        wr(4'h0, 8'h02);
        settle(3);
        chk("pch", pch, 8'h00);
        chk("seg_h", sh, 8'h00);
        chk("xrst", xrst, 1'b0);
        chk("pad_h", pad_h, 32'h0000_0000);
        chk("in_h", pin_h, 8'h00);
        rd(4'h3, 8'h00);
        final_report;
    end

    // Tests need about 70 cycles
    initial
    begin
        repeat (2000) @(posedge clk);
        errors++;
        final_report;
    end
endmodule

`default_nettype wire
